/* rtl/fc_reg_map.sv */
// register number to mirror slot decoder
// assumes a combinational caller on the same clock
`timescale 1ns/1ps
`include "fcmirror_defines.svh"

module fc_reg_map
   import fcmirror_pkg::*;
(
   input wire reg_num_t regNum,
   output slot_t slot,
   output logic valid
);

   reg_num_t biased;
   logic [4:0] gIdx;
   logic gOk;

   always_comb begin
      biased = regNum - `FC_REG_BIAS;
      gIdx = 5'h00;
      gOk = 1'b0;
      for (int i = 0; i < `FC_GROUPS; i++) begin
         if (GROUP_NUM[i] == biased[12:8]) begin
            gIdx = 5'(i);
            gOk = 1'b1;
         end
      end
      // register zero and anything past the top are refused
      valid = gOk && (regNum != 13'h0000) && (regNum <= `FC_MAX_REG)
         && (biased[7:0] <= `FC_MAX_OFFSET);
      // widen before the product: group times 100 overflows seven bits
      slot = slot_t'(gIdx) * slot_t'(`FC_OFFSETS) + {3'h0, biased[7:0]};
   end

endmodule

/* rtl/fcmirror_defines.svh */
// constants for the function code register mirror
// assumes inclusion wherever the macros are read; the guard keeps it single
`ifndef FCMIRROR_DEFINES_SVH
`define FCMIRROR_DEFINES_SVH

`define FC_GROUP_SCALE 13'h100
`define FC_REG_BIAS 13'h001
`define FC_MAX_REG 13'h1364
`define FC_MAX_OFFSET 8'h63
`define FC_OFFSETS 100
`define FC_GROUPS 17
`define FC_DATA_W 16
`define FC_MIRROR_RESET 16'h0000

`define FC_GRP_F 5'h00
`define FC_GRP_E 5'h01
`define FC_GRP_C 5'h02
`define FC_GRP_P 5'h03
`define FC_GRP_H 5'h04
`define FC_GRP_A 5'h05
`define FC_GRP_O 5'h06
`define FC_GRP_S 5'h07
`define FC_GRP_M 5'h08
`define FC_GRP_R 5'h0A
`define FC_GRP_J 5'h0D
`define FC_GRP_Y 5'h0E
`define FC_GRP_W 5'h0F
`define FC_GRP_X 5'h10
`define FC_GRP_Z 5'h11
`define FC_GRP_B 5'h12
`define FC_GRP_D 5'h13

`endif

/* rtl/fcmirror_pkg.sv */
// types and group lookups for the function code register mirror
// assumes the defines header sits beside it
`include "fcmirror_defines.svh"

package fcmirror_pkg;

   typedef logic [12:0] reg_num_t;
   typedef logic [10:0] slot_t;
   typedef logic [4:0] group_t;

   typedef enum logic [1:0] {
      SCAN_PICK,
      SCAN_WAIT,
      SCAN_STEP
   } scan_state_e;

   // group number of each compact group index, in ascending group number order
   localparam group_t GROUP_NUM [`FC_GROUPS] = '{
      `FC_GRP_F, `FC_GRP_E, `FC_GRP_C, `FC_GRP_P, `FC_GRP_H, `FC_GRP_A,
      `FC_GRP_O, `FC_GRP_S, `FC_GRP_M, `FC_GRP_R, `FC_GRP_J, `FC_GRP_Y,
      `FC_GRP_W, `FC_GRP_X, `FC_GRP_Z, `FC_GRP_B, `FC_GRP_D};

   // register number from compact group index and decimal offset
   function automatic reg_num_t regNumber(input logic [4:0] gIdx, input logic [6:0] off);
      reg_num_t grp;
      grp = {8'h00, GROUP_NUM[gIdx]};
      return reg_num_t'(grp * `FC_GROUP_SCALE) + {6'h00, off} + `FC_REG_BIAS;
   endfunction

endpackage

/* rtl/function_code_register_mirror.sv */
// function code mirror: network word access plus endless inverter scan
// assumes network and inverter ports come from logic on clk
`timescale 1ns/1ps
`include "fcmirror_defines.svh"

module function_code_register_mirror
   import fcmirror_pkg::*;
#(
   parameter int DATA_W = `FC_DATA_W,
   parameter int SLOTS = `FC_GROUPS * `FC_OFFSETS
) (
   input wire logic clk,
   input wire logic rstn,
   input wire logic netReq,
   input wire logic netWrite,
   input wire reg_num_t netRegNum,
   input wire logic [DATA_W-1:0] netWdata,
   output logic netAck,
   output logic netErr,
   output logic [DATA_W-1:0] netRdata,
   input wire logic cfgWe,
   input wire reg_num_t cfgRegNum,
   input wire logic cfgScanned,
   output logic invReq,
   output logic invWrite,
   output reg_num_t invRegNum,
   output logic [DATA_W-1:0] invWdata,
   input wire logic invAck,
   input wire logic [DATA_W-1:0] invRdata
);

   if (DATA_W != `FC_DATA_W || SLOTS < `FC_GROUPS * `FC_OFFSETS) begin : g_check
      $error("mirror needs 16-bit words and one slot per possible code");
   end

   // one word and two flags per slot; pending marks data owed to the inverter
   logic [DATA_W-1:0] mirror [SLOTS];
   logic [SLOTS-1:0] scanned;
   logic [SLOTS-1:0] pending;

   slot_t netSlot, cfgSlot, curSlot;
   logic netValid, cfgValid;

   // same decode for both network and configuration, so numbering is shared
   fc_reg_map u_net_map (.regNum(netRegNum), .slot(netSlot), .valid(netValid));
   fc_reg_map u_cfg_map (.regNum(cfgRegNum), .slot(cfgSlot), .valid(cfgValid));

   // network side
   logic netWe;
   logic next_netAck, next_netErr;
   logic [DATA_W-1:0] next_netRdata;

   always_comb begin
      // each word stands alone, so blocks across absent codes just work
      netWe = netReq && netWrite && netValid;
      next_netAck = netReq;
      next_netErr = netReq && !netValid;
      next_netRdata = netRdata;
      if (netReq && !netWrite && netValid) begin
         next_netRdata = mirror[netSlot];
      end
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         netAck <= 1'b0;
         netErr <= 1'b0;
         netRdata <= `FC_MIRROR_RESET;
      end else begin
         netAck <= next_netAck;
         netErr <= next_netErr;
         netRdata <= next_netRdata;
      end
   end

   // scanner
   scan_state_e state, next_state;
   logic [4:0] scanGrp, next_scanGrp;
   logic [6:0] scanOff, next_scanOff;
   logic next_invReq, next_invWrite;
   reg_num_t next_invRegNum;
   logic [DATA_W-1:0] next_invWdata;
   logic issueWrite, readBack;

   assign curSlot = slot_t'(scanGrp) * slot_t'(`FC_OFFSETS) + {4'h0, scanOff};

   always_comb begin
      next_state = state;
      next_scanGrp = scanGrp;
      next_scanOff = scanOff;
      next_invReq = invReq;
      next_invWrite = invWrite;
      next_invRegNum = invRegNum;
      next_invWdata = invWdata;
      issueWrite = 1'b0;
      readBack = 1'b0;
      unique case (state)
         SCAN_PICK: begin
            if (scanned[curSlot]) begin
               next_invReq = 1'b1;
               next_invWrite = pending[curSlot];
               issueWrite = pending[curSlot];
               next_invRegNum = regNumber(scanGrp, scanOff);
               next_invWdata = mirror[curSlot];
               next_state = SCAN_WAIT;
            end else begin
               next_state = SCAN_STEP;
            end
         end
         SCAN_WAIT: begin
            if (invAck) begin
               next_invReq = 1'b0;
               next_invWrite = 1'b0;
               // a fresh net write outranks the inverter's stale value
               readBack = !invWrite && !pending[curSlot]
                  && !(netWe && netSlot == curSlot);
               next_state = SCAN_STEP;
            end
         end
         SCAN_STEP: begin
            next_state = SCAN_PICK;
            if (scanOff == 7'(`FC_MAX_OFFSET)) begin
               next_scanOff = 7'h00;
               next_scanGrp = (scanGrp == 5'(`FC_GROUPS - 1)) ? 5'h00 : scanGrp + 5'h01;
            end else begin
               next_scanOff = scanOff + 7'h01;
            end
         end
      endcase
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         state <= SCAN_PICK;
         scanGrp <= 5'h00;
         scanOff <= 7'h00;
         invReq <= 1'b0;
         invWrite <= 1'b0;
         invRegNum <= 13'h0000;
         invWdata <= `FC_MIRROR_RESET;
      end else begin
         state <= next_state;
         scanGrp <= next_scanGrp;
         scanOff <= next_scanOff;
         invReq <= next_invReq;
         invWrite <= next_invWrite;
         invRegNum <= next_invRegNum;
         invWdata <= next_invWdata;
      end
   end

   // mirror storage; one port each for network, scan and configuration
   logic [SLOTS-1:0] next_scanned, next_pending;

   always_comb begin
      next_scanned = scanned;
      next_pending = pending;
      if (cfgWe && cfgValid) begin
         next_scanned[cfgSlot] = cfgScanned;
      end
      // clear at issue, set by net write after: a set in the same cycle wins
      if (issueWrite) begin
         next_pending[curSlot] = 1'b0;
      end
      if (netWe) begin
         next_pending[netSlot] = 1'b1;
      end
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         scanned <= '0;
         pending <= '0;
      end else begin
         scanned <= next_scanned;
         pending <= next_pending;
      end
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         for (int i = 0; i < SLOTS; i++) begin
            mirror[i] <= `FC_MIRROR_RESET;
         end
      end else begin
         if (readBack) begin
            mirror[curSlot] <= invRdata;
         end
         if (netWe) begin
            mirror[netSlot] <= netWdata;
         end
      end
   end

   // checks
   sequence s_netWriteOk;
      netReq && netWrite && netValid;
   endsequence

   sequence s_answerClean;
      netAck && !netErr;
   endsequence

   property p_validOk;
      @(posedge clk) disable iff (!rstn)
         netReq && netValid |-> ##1 s_answerClean;
   endproperty
   a_validOk: assert property (p_validOk) else $error("valid access answered with error");

   property p_overMax;
      @(posedge clk) disable iff (!rstn)
         netReq && netRegNum > `FC_MAX_REG |-> ##1 (netAck && netErr);
   endproperty
   a_overMax: assert property (p_overMax) else $error("register past top not refused");

   property p_writeStored;
      @(posedge clk) disable iff (!rstn)
         s_netWriteOk ##1 1'b1 |-> mirror[$past(netSlot)] == $past(netWdata);
   endproperty
   a_writeStored: assert property (p_writeStored) else $error("net write not stored");

   property p_writePending;
      @(posedge clk) disable iff (!rstn)
         s_netWriteOk |=> pending[$past(netSlot)];
   endproperty
   a_writePending: assert property (p_writePending) else $error("net write not queued");

   property p_readBack;
      @(posedge clk) disable iff (!rstn)
         readBack |=> mirror[$past(curSlot)] == $past(invRdata);
   endproperty
   a_readBack: assert property (p_readBack) else $error("scanned read not mirrored");

   property p_onlyScanned;
      @(posedge clk) disable iff (!rstn)
         $rose(invReq) |-> scanned[$past(curSlot)];
   endproperty
   a_onlyScanned: assert property (p_onlyScanned) else $error("unconfigured code scanned");

   property p_regRange;
      @(posedge clk) disable iff (!rstn)
         invReq |-> invRegNum != 13'h0000 && invRegNum <= `FC_MAX_REG
            && ((invRegNum - `FC_REG_BIAS) & 13'h00FF) <= 13'h0063;
   endproperty
   a_regRange: assert property (p_regRange) else $error("scan register number malformed");

   property p_holdReq;
      @(posedge clk) disable iff (!rstn)
         invReq && !invAck |=> invReq && $stable(invRegNum) && $stable(invWrite);
   endproperty
   a_holdReq: assert property (p_holdReq) else $error("inverter request dropped");

   property p_forward;
      @(posedge clk) disable iff (!rstn)
         state == SCAN_PICK && scanned[curSlot] && pending[curSlot]
            |=> invReq && invWrite && invWdata == $past(mirror[curSlot]);
   endproperty
   a_forward: assert property (p_forward) else $error("pending word not forwarded");

endmodule

/* sim/function_code_register_mirror_tb.sv */
// bench for the function code mirror: net access, refusals, scan
// assumes the store model stands on the scan port
`timescale 1ns/1ps
module function_code_register_mirror_tb;
   import fcmirror_pkg::*;
   logic clk = 1'b0;
   logic rstn = 1'b0;
   logic netReq = 1'b0, netWrite = 1'b0, cfgWe = 1'b0, cfgScanned = 1'b0, reject = 1'b0;
   reg_num_t netRegNum = 13'h0000, cfgRegNum = 13'h0000, invRegNum;
   logic [15:0] netWdata = 16'h0000, netRdata, invWdata, invRdata;
   logic netAck, netErr, invReq, invWrite, invAck;
   logic [7:0] delay = 8'h00;
   int miscompares = 0, totalChecks = 0, cycles = 0;
   int grp [17] = '{0, 1, 2, 3, 4, 5, 6, 7, 8, 10, 13, 14, 15, 16, 17, 18, 19};
   always #2 clk = ~clk;
   function_code_register_mirror function_code_register_mirror_i (.clk(clk), .rstn(rstn),
      .netReq(netReq), .netWrite(netWrite), .netRegNum(netRegNum), .netWdata(netWdata),
      .netAck(netAck), .netErr(netErr), .netRdata(netRdata), .cfgWe(cfgWe),
      .cfgRegNum(cfgRegNum), .cfgScanned(cfgScanned), .invReq(invReq), .invWrite(invWrite),
      .invRegNum(invRegNum), .invWdata(invWdata), .invAck(invAck), .invRdata(invRdata));
   inverter_store_model inverter_store_model_i (.clk(clk), .rstn(rstn), .invReq(invReq),
      .invWrite(invWrite), .invRegNum(invRegNum), .invWdata(invWdata), .reject(reject),
      .delay(delay), .invAck(invAck), .invRdata(invRdata));
   task automatic completeRun;
      $display("checks %0d mismatches %0d", totalChecks, miscompares);
      if (miscompares == 0 && totalChecks > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask
   task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
      totalChecks++;
      if (seen !== exp) begin
         miscompares++;
         $display("mismatch %s expected %h seen %h", what, exp, seen);
      end
   endtask
   function automatic logic [15:0] initVal(input reg_num_t r);
      return {3'h0, r} ^ 16'h5A5A;
   endfunction
   task automatic acc(input logic wr, input reg_num_t r, input logic [15:0] d,
                      input logic err, input logic [15:0] exp);
      @(posedge clk);
      #1 netReq = 1'b1;
      netWrite = wr;
      netRegNum = r;
      netWdata = d;
      @(posedge clk);
      #1 netReq = 1'b0;
      check("ack", {15'h0, netAck}, 16'h0001);
      check("err", {15'h0, netErr}, {15'h0, err});
      if (!wr && !err) check("rdata", netRdata, exp);
   endtask
   task automatic cfgSet(input reg_num_t r);
      @(posedge clk);
      #1 cfgWe = 1'b1;
      cfgRegNum = r;
      cfgScanned = 1'b1;
      @(posedge clk);
      #1 cfgWe = 1'b0;
   endtask
   task automatic waitInv(input reg_num_t r, input logic wr, input logic [15:0] d);
      int n;
      n = 0;
      while (!(invReq && invAck && invRegNum === r && invWrite === wr) && n < 20000) begin
         @(posedge clk);
         #1 n++;
      end
      check("scan hit", {15'h0, n < 20000}, 16'h0001);
      if (wr) check("invWdata", invWdata, d);
      repeat (3) @(posedge clk);
   endtask
   task automatic t_map;
      reg_num_t r;
      acc(1'b0, 13'h0163, 16'h0000, 1'b0, 16'h0000);
      for (int g = 0; g < 17; g++) begin
         r = reg_num_t'(grp[g] * 256 + 1);
         acc(1'b1, r, 16'(g), 1'b0, 16'h0000);
         acc(1'b1, r + 13'h0063, 16'hFFFF ^ 16'(g), 1'b0, 16'h0000);
         acc(1'b0, r, 16'h0000, 1'b0, 16'(g));
         acc(1'b0, r + 13'h0063, 16'h0000, 1'b0, 16'hFFFF ^ 16'(g));
      end
      $display("test map done");
   endtask
   task automatic t_refuse;
      int bad [7] = '{0, 4965, 2305, 2817, 3073, 5121, 101};
      foreach (bad[i]) begin
         acc(1'b1, reg_num_t'(bad[i]), 16'h1234, 1'b1, 16'h0000);
         acc(1'b0, reg_num_t'(bad[i]), 16'h0000, 1'b1, 16'h0000);
      end
      acc(1'b0, 13'h0064, 16'h0000, 1'b0, 16'hFFFF);
      $display("test refuse done");
   endtask
   // back to back words, the last one just past offset 99
   task automatic t_block(input logic wr);
      @(posedge clk);
      for (int i = 0; i < 5; i++) begin
         #1 if (i > 0) begin
            check("blk ack", {15'h0, netAck}, 16'h0001);
            check("blk err", {15'h0, netErr}, {15'h0, i == 4});
            if (!wr && i < 4) check("blk rdata", netRdata, 16'(i - 1) * 16'h1111);
         end
         netReq = (i < 4);
         netWrite = wr;
         netRegNum = reg_num_t'(2146 + i);
         netWdata = 16'(i) * 16'h1111;
         @(posedge clk);
      end
      $display("test block done");
   endtask
   task automatic t_scan;
      cfgSet(13'h080A);
      cfgSet(13'h0706);
      waitInv(13'h080A, 1'b0, 16'h0000);
      acc(1'b0, 13'h080A, 16'h0000, 1'b0, initVal(13'h080A));
      delay = 8'h03;
      reject = 1'b1;
      acc(1'b1, 13'h0706, 16'hFFFF, 1'b0, 16'h0000);
      acc(1'b0, 13'h0706, 16'h0000, 1'b0, 16'hFFFF);
      waitInv(13'h0706, 1'b1, 16'hFFFF);
      waitInv(13'h0706, 1'b0, 16'h0000);
      acc(1'b0, 13'h0706, 16'h0000, 1'b0, initVal(13'h0706));
      reject = 1'b0;
      acc(1'b1, 13'h0706, 16'h01F4, 1'b0, 16'h0000);
      waitInv(13'h0706, 1'b1, 16'h01F4);
      waitInv(13'h0706, 1'b0, 16'h0000);
      acc(1'b0, 13'h0706, 16'h0000, 1'b0, 16'h01F4);
      $display("test scan done");
   endtask
   // reset in mid-run: scan stops, mirror and scan list start empty again
   task automatic t_reset;
      @(posedge clk);
      #1 rstn = 1'b0;
      repeat (2) @(posedge clk);
      #1 check("rst invReq", {15'h0, invReq}, 16'h0000);
      check("rst netAck", {15'h0, netAck}, 16'h0000);
      rstn = 1'b1;
      acc(1'b0, 13'h0706, 16'h0000, 1'b0, 16'h0000);
      repeat (8) @(posedge clk);
      #1 check("idle invReq", {15'h0, invReq}, 16'h0000);
      $display("test reset done");
   endtask
   // several scan passes of about 3400 cycles fit well inside this
   always @(posedge clk) begin
      cycles++;
      if (cycles == 90000) begin
         miscompares++;
         completeRun();
      end
   end
   initial begin
      repeat (20) @(posedge clk);
      #1 rstn = 1'b1;
      t_map();
      t_refuse();
      t_block(1'b1);
      t_block(1'b0);
      t_scan();
      t_reset();
      completeRun();
   end
endmodule

/* sim/inverter_store_model.sv */
// inverter parameter store answering the scan port
// assumes the mirror scan drives requests on clk
`timescale 1ns/1ps
module inverter_store_model (
   input wire logic clk,
   input wire logic rstn,
   input wire logic invReq,
   input wire logic invWrite,
   input wire logic [12:0] invRegNum,
   input wire logic [15:0] invWdata,
   input wire logic reject,
   input wire logic [7:0] delay,
   output logic invAck,
   output logic [15:0] invRdata
);
   logic [15:0] mem [int];
   int cnt = 0;
   initial begin
      invAck = 1'b0;
      invRdata = 16'h0000;
   end
   always @(posedge clk) begin
      invAck <= 1'b0;
      // data is stale outside the answer, so keep it moving
      invRdata <= ~invRdata;
      if (!rstn || !invReq || invAck) begin
         cnt <= 0;
      end else if (cnt < delay) begin
         cnt <= cnt + 1;
      end else begin
         invAck <= 1'b1;
         cnt <= 0;
         // a rejected write leaves the old value in place
         if (invWrite && !reject) mem[invRegNum] = invWdata;
         if (mem.exists(invRegNum)) invRdata <= mem[invRegNum];
         else invRdata <= {3'h0, invRegNum} ^ 16'h5A5A;
      end
   end
endmodule
